// ===== bcp_params.svh
// Offsets, field positions, reset values and widths of the control register
`ifndef BCP_PARAMS_SVH
`define BCP_PARAMS_SVH

`define BCP_ADDR_W 8
`define BCP_PCI_OFFSET 8'h6C
`define BCP_LOC_OFFSET 8'hEC

`define BCP_DMA_RD_LSB 0
`define BCP_DMA_WR_LSB 4
`define BCP_DM_RD_LSB 8
`define BCP_DM_WR_LSB 12
`define BCP_GPO_BIT 16
`define BCP_GPI_BIT 17
`define BCP_EE_CLK_BIT 24
`define BCP_EE_CS_BIT 25
`define BCP_EE_DI_BIT 26
`define BCP_EE_DO_BIT 27
`define BCP_EE_PRES_BIT 28
`define BCP_RELOAD_BIT 29
`define BCP_SWRST_BIT 30
`define BCP_INIT_BIT 31

`define BCP_CMD_RD_RST 4'hC
`define BCP_CMD_WR_RST 4'h7
`define BCP_DMA_RD_ALT_RST 4'hE
`define BCP_DM_RD_ALT_RST 4'h6
`define BCP_REG_RST 32'h88037C7C
`define BCP_REG_ALT_RST 32'h8803767E
`define BCP_SYNC_STAGES 2

`endif

// ===== bcp_pkg.sv
// Types shared by the command, serial-prom and init control register block
package bcp_pkg;
  `include "bcp_params.svh"

  typedef struct packed {
    logic [`BCP_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcp_req_type;

  typedef struct packed {
    logic [3:0] dm_wr;
    logic [3:0] dm_rd;
    logic [3:0] dma_wr;
    logic [3:0] dma_rd;
  } bcp_cmd_type;

  typedef struct packed {
    logic clk;
    logic cs;
    logic di;
  } bcp_prom_type;
endpackage : bcp_pkg

// ===== bcp_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bcp_sync import bcp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bcp_sync

// ===== bcp_reg_port.sv
// One register access port: decode, retry gating and registered read data
`timescale 1ns/1ps
`include "bcp_params.svh"
module bcp_reg_port import bcp_pkg::*; #(
  parameter logic [`BCP_ADDR_W-1:0] OFFSET = `BCP_PCI_OFFSET
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire bcp_req_type req,
  input wire logic allow,
  input wire logic [31:0] reg_value,
  output logic wr_hit,
  output logic retry,
  output logic ack_q,
  output logic [31:0] rdata_q
);
  wire access = req.wr | req.rd;
  wire addr_hit = (req.addr == OFFSET);
  wire rd_hit = req.rd & allow & addr_hit;

  assign wr_hit = req.wr & allow & addr_hit;
  assign retry = access & ~allow;

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= access & allow;
      rdata_q <= rd_hit ? reg_value : 32'h0000_0000;
    end
  end
endmodule : bcp_reg_port

// ===== bcp_cmd_init_ctrl.sv
// Bus command codes, serial-prom bit-bang, user pins and init control
// Function
// - Bits 3:0 hold DMA read command code, reset 1100.
// - Bits 7:4 hold DMA write command code, reset 0111.
// - Bits 11:8 hold direct-master memory read code, reset 1100.
// - Bits 15:12 hold direct-master memory write code, reset 0111.
// - Alternative board resets DMA read to 1110, DM read to 0110.
// - Bit 16 drives general output pin directly, reset 1.
// - Bit 17 reads back the general input pin level.
// - Bit 24 drives prom clock; software toggles it per pulse.
// - Bit 25 drives prom chip select, active when 1, either side.
// - Bit 26 drives prom serial data input.
// - Bit 27 returns prom serial data output, reset 1.
// - Bit 28 reads 1 when a prom is present, reset 0.
// - Writing 1 to bit 29 while 0 starts configuration reload.
// - Bit 30 set resets bridge and drives local bus reset.
// - Software reset leaves configuration register contents unchanged.
// - Only host-side writes may clear the software reset bit.
// - While bit 31 is 0, host accesses end in retry.
// - Register sits at 6Ch host side and ECh local side.
// - Whole register resets to 88037C7Ch.
`timescale 1ns/1ps
`include "bcp_params.svh"
module bcp_cmd_init_ctrl import bcp_pkg::*; #(
  parameter bit ALT_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire bcp_req_type pci_req,
  output logic [31:0] pci_rdata,
  output logic pci_ack,
  output logic pci_retry,
  input wire bcp_req_type loc_req,
  output logic [31:0] loc_rdata,
  output logic loc_ack,
  output bcp_cmd_type cmd_codes,
  output logic general_output_pin,
  input wire logic general_input_pin,
  output bcp_prom_type prom_pins,
  input wire logic prom_data_out,
  input wire logic prom_present,
  output logic reload_start,
  input wire logic reload_done,
  output logic bridge_reset,
  output logic local_bus_reset
);
  localparam logic [3:0] DMA_RD_RST =
    ALT_VARIANT ? `BCP_DMA_RD_ALT_RST : `BCP_CMD_RD_RST;
  localparam logic [3:0] DM_RD_RST =
    ALT_VARIANT ? `BCP_DM_RD_ALT_RST : `BCP_CMD_RD_RST;
  localparam logic [31:0] REG_RST =
    ALT_VARIANT ? `BCP_REG_ALT_RST : `BCP_REG_RST;
  localparam bcp_cmd_type CMD_RST = '{dm_wr: `BCP_CMD_WR_RST,
    dm_rd: DM_RD_RST, dma_wr: `BCP_CMD_WR_RST, dma_rd: DMA_RD_RST};

  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic gpo_q;
  logic gpo_d;
  logic [2:0] prom_q;
  logic [2:0] prom_d;
  logic init_q;
  logic init_d;
  logic swrst_q;
  logic swrst_d;
  logic reload_busy_q;
  logic reload_busy_d;
  logic reload_start_q;
  logic [2:0] pins_s;
  logic [31:0] reg_value;
  logic pci_wr_hit;
  logic loc_wr_hit;

  // Host-side port is held off with retry until local init completes
  bcp_reg_port #(.OFFSET(`BCP_PCI_OFFSET)) u_pci_port (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .req(pci_req),
    .allow(init_q),
    .reg_value(reg_value),
    .wr_hit(pci_wr_hit),
    .retry(pci_retry),
    .ack_q(pci_ack),
    .rdata_q(pci_rdata)
  );

  bcp_reg_port #(.OFFSET(`BCP_LOC_OFFSET)) u_loc_port (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .req(loc_req),
    .allow(1'b1),
    .reg_value(reg_value),
    .wr_hit(loc_wr_hit),
    .retry(),
    .ack_q(loc_ack),
    .rdata_q(loc_rdata)
  );

  // Pin order: prom present, prom data out, general input; reset 0,1,1
  bcp_sync #(.W(3), .RST_VAL(3'h3)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .async_in({prom_present, prom_data_out, general_input_pin}),
    .sync_out(pins_s)
  );

  // Byte-lane write enables; the host side wins a same-cycle collision, except against a local set of bit 29 or bit 30
  wire [3:0] loc_bw = {4{loc_wr_hit}} & loc_req.be;
  wire [3:0] pci_bw = {4{pci_wr_hit}} & pci_req.be;

  function automatic logic [31:0] bcp_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] bw);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (bw[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : bcp_merge

  wire [31:0] loc_merged = bcp_merge(reg_value, loc_req.wdata, loc_bw);
  wire [31:0] wr_value = bcp_merge(loc_merged, pci_req.wdata, pci_bw);

  assign cmd_d = wr_value[15:0];
  assign gpo_d = wr_value[`BCP_GPO_BIT];
  assign prom_d = wr_value[`BCP_EE_DI_BIT:`BCP_EE_CLK_BIT];
  assign init_d = wr_value[`BCP_INIT_BIT];

  wire loc_top = loc_bw[3];
  wire pci_top = pci_bw[3];
  wire swrst_set = (loc_top & loc_req.wdata[`BCP_SWRST_BIT])
    | (pci_top & pci_req.wdata[`BCP_SWRST_BIT]);
  wire swrst_clr = pci_top & ~pci_req.wdata[`BCP_SWRST_BIT];
  // Set wins over clear; the local side can never clear it
  assign swrst_d = swrst_set | (swrst_q & ~swrst_clr);

  wire reload_req = ~reload_busy_q & (
    (loc_top & loc_req.wdata[`BCP_RELOAD_BIT])
    | (pci_top & pci_req.wdata[`BCP_RELOAD_BIT]));
  // Bit 29 reads 1 while a reload runs; a new start wins over done
  assign reload_busy_d = reload_req | (reload_busy_q & ~reload_done);

  // Only rst clears this bank; the soft reset just drives outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_q <= CMD_RST;
      gpo_q <= 1'b1;
      prom_q <= 3'h0;
      init_q <= 1'b1;
      swrst_q <= 1'b0;
      reload_busy_q <= 1'b0;
      reload_start_q <= 1'b0;
    end else if (ce) begin
      cmd_q <= cmd_d;
      gpo_q <= gpo_d;
      prom_q <= prom_d;
      init_q <= init_d;
      swrst_q <= swrst_d;
      reload_busy_q <= reload_busy_d;
      reload_start_q <= reload_req;
    end
  end

  assign reg_value = {init_q, swrst_q, reload_busy_q,
    pins_s[2],
    pins_s[1],
    prom_q,
    6'h00,
    pins_s[0],
    gpo_q, cmd_q};

  assign cmd_codes = cmd_q;
  assign general_output_pin = gpo_q;
  assign prom_pins.clk = prom_q[0];
  assign prom_pins.cs = prom_q[1];
  assign prom_pins.di = prom_q[2];
  assign reload_start = reload_start_q;
  assign bridge_reset = swrst_q;
  assign local_bus_reset = swrst_q;

  sequence s_reload_write;
    ce && reload_req;
  endsequence

  sequence s_start_pulse;
    reload_start ##1 (!reload_start || !$past(ce));
  endsequence

  AST_RESET_VALUE: assert property (
    @(posedge ref_clk) $past(rst) && !rst |-> reg_value == REG_RST)
    else $error("register value wrong after reset");

  AST_RETRY_GATE: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pci_req.rd || pci_req.wr) && !init_q && ce
      |-> pci_retry ##1 !pci_ack)
    else $error("host access not retried before init");

  AST_HOST_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && init_q && pci_req.rd && pci_req.addr == `BCP_PCI_OFFSET
      |=> pci_ack && pci_rdata == $past(reg_value))
    else $error("host read at register offset wrong");

  AST_LOCAL_CMD: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && loc_req.wr && loc_req.be[0] && loc_req.addr == `BCP_LOC_OFFSET
      && !pci_bw[0] |=> cmd_codes.dma_rd == $past(loc_req.wdata[3:0]))
    else $error("local write to DMA read code lost");

  AST_GPO_PIN: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[2] |=> general_output_pin == $past(pci_req.wdata[16]))
    else $error("general output pin does not follow write");

  AST_SWRST_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    swrst_q && !pci_top |=> swrst_q)
    else $error("soft reset cleared without host write");

  AST_SWRST_SET: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && loc_top && loc_req.wdata[30] |=> bridge_reset && local_bus_reset)
    else $error("soft reset not raised by write of one");

  AST_RELOAD_PULSE: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reload_write |=> s_start_pulse)
    else $error("reload start is not a single pulse");

  AST_GPI_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    (ce && general_input_pin)[*3] |-> reg_value[17])
    else $error("input pin level not reflected");

  AST_UNUSED_ZERO: assert property (
    @(posedge ref_clk) disable iff (rst) reg_value[23:18] == 6'h00)
    else $error("unused bits not zero");

  AST_PROM_CS: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && loc_bw[3] && !pci_bw[3]
      |=> prom_pins.cs == $past(loc_req.wdata[25]))
    else $error("prom chip select does not follow write");

  AST_HOST_DMA_WR: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[0] |=> cmd_codes.dma_wr == $past(pci_req.wdata[7:4]))
    else $error("host write to DMA write code lost");

  AST_HOST_DM_RD: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[1] |=> cmd_codes.dm_rd == $past(pci_req.wdata[11:8]))
    else $error("host write to memory read code lost");

  AST_HOST_DM_WR: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[1] |=> cmd_codes.dm_wr == $past(pci_req.wdata[15:12]))
    else $error("host write to memory write code lost");

  AST_RETRY_NO_WRITE: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_retry && !loc_wr_hit
      |=> $stable(cmd_codes) && $stable(general_output_pin))
    else $error("retried host access changed the register");

  AST_LOCAL_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && loc_req.rd && loc_req.addr == `BCP_LOC_OFFSET
      |=> loc_ack && loc_rdata == $past(reg_value))
    else $error("local read at register offset wrong");

  AST_RELOAD_BUSY: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reload_write |=> reg_value[`BCP_RELOAD_BIT])
    else $error("reload bit not set while reload runs");

  AST_PROM_CLK: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[3] |=> prom_pins.clk == $past(pci_req.wdata[24]))
    else $error("prom clock does not follow write");

  AST_PROM_DI: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_bw[3] |=> prom_pins.di == $past(pci_req.wdata[26]))
    else $error("prom data input does not follow write");

  AST_SWRST_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && pci_top && !pci_req.wdata[30] && !(loc_top && loc_req.wdata[30])
      |=> !bridge_reset)
    else $error("host clear of soft reset ignored");

  AST_PRESENT_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    (ce && prom_present)[*3] |-> reg_value[28])
    else $error("prom present level not reflected");

endmodule : bcp_cmd_init_ctrl

// ===== bcp_far_model.sv
// Serial prom and reload engine standing on the far side of the register
`timescale 1ns/1ps
module bcp_far_model import bcp_pkg::*; #(
  parameter logic [7:0] PATTERN = 8'hA5,
  parameter int DLY = 5
) (
  input wire logic ref_clk,
  input wire logic fitted,
  input wire bcp_prom_type prom_pins,
  input wire logic reload_start,
  output logic prom_data_out,
  output logic prom_present,
  output logic reload_done
);
  logic [7:0] sh_q;
  int cnt;
  assign prom_present = fitted;
  // Data line is pulled up while the prom is not selected
  assign prom_data_out = prom_pins.cs ? sh_q[7] : 1'b1;
  initial begin
    sh_q = PATTERN;
    reload_done = 1'b0;
    cnt = 0;
  end
  always @(posedge prom_pins.clk) begin
    if (prom_pins.cs) sh_q <= {sh_q[6:0], prom_pins.di};
  end
  // Reload takes a few cycles, so the busy bit is seen set first
  always @(posedge ref_clk) begin
    reload_done <= (cnt == 1);
    if (reload_start) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : bcp_far_model

// ===== bus_cmd_prom_init_ctrl_test.sv
// Register-level bench for the command, prom and init control block
`timescale 1ns/1ps
module bus_cmd_prom_init_ctrl_test;
  import bcp_pkg::*;
  localparam logic [7:0] HA = 8'h6C;
  localparam logic [7:0] LA = 8'hEC;
  localparam logic [7:0] PAT = 8'hA5;
  logic ref_clk, rst, ce, pci_ack, pci_retry, loc_ack, fitted;
  logic general_output_pin, general_input_pin, prom_data_out;
  logic prom_present, reload_start, reload_done;
  logic bridge_reset, local_bus_reset;
  logic [31:0] pci_rdata, loc_rdata, q;
  logic rs;
  bcp_req_type pci_req, loc_req;
  bcp_cmd_type cmd_codes, alt_cmd;
  bcp_prom_type prom_pins;
  int error_cnt = 0;
  int n_checks = 0;
  int i;
  bcp_cmd_init_ctrl u_dut (.ref_clk, .rst, .ce, .pci_req, .pci_rdata,
    .pci_ack, .pci_retry, .loc_req, .loc_rdata, .loc_ack, .cmd_codes,
    .general_output_pin, .general_input_pin, .prom_pins, .prom_data_out,
    .prom_present, .reload_start, .reload_done, .bridge_reset,
    .local_bus_reset);
  bcp_cmd_init_ctrl #(.ALT_VARIANT(1'b1)) u_alt (.ref_clk, .rst, .ce,
    .pci_req(pci_req), .pci_rdata(), .pci_ack(), .pci_retry(),
    .loc_req(loc_req), .loc_rdata(), .loc_ack(), .cmd_codes(alt_cmd),
    .general_output_pin(), .general_input_pin, .prom_pins(),
    .prom_data_out(1'b1), .prom_present(1'b0), .reload_start(),
    .reload_done(1'b0), .bridge_reset(), .local_bus_reset());
  bcp_far_model #(.PATTERN(PAT)) u_far (.ref_clk, .fitted, .prom_pins,
    .reload_start, .prom_data_out, .prom_present, .reload_done);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One access over one taking edge; the answer stands for one cycle only,
  // so it is read at the next falling edge, then one idle edge follows
  task automatic acc(input bit p, input bit w, input logic [3:0] be,
      input logic [31:0] d);
    bcp_req_type r;
    r = '{addr: (p ? LA : HA), wr: w, rd: !w, be: be, wdata: d};
    if (p) loc_req = r;
    else pci_req = r;
    @(negedge ref_clk);
    q = p ? loc_rdata : pci_rdata;
    rs = reload_start;
    chk({31'h0, p ? loc_ack : pci_ack}, 32'h1);
    pci_req = '0;
    loc_req = '0;
    @(negedge ref_clk);
  endtask : acc

  task automatic b3(input bit p, input logic [7:0] v);
    acc(p, 1'b1, 4'h8, {v, 24'h0});
  endtask : b3

  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    fitted = 1'b0;
    general_input_pin = 1'b1;
    pci_req = '0;
    loc_req = '0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk({16'h0, alt_cmd}, 32'h767E);
    acc(0, 0, 4'hF, 0);
    chk(q, 32'h88037C7C);
    acc(1, 0, 4'hF, 0);
    chk(q, 32'h88037C7C);
    acc(1, 1, 4'h3, 32'h0000A5C3);
    chk({16'h0, cmd_codes}, 32'hA5C3);
    acc(0, 1, 4'h4, 32'h00FE0000);
    chk({31'h0, general_output_pin}, 0);
    general_input_pin = 1'b0;
    fitted = 1'b1;
    repeat (3) @(negedge ref_clk);
    acc(0, 0, 4'hF, 0);
    chk(q, 32'h9800A5C3);
    b3(0, 8'h86);
    chk({29'h0, prom_pins}, 32'h3);
    for (i = 7; i > 3; i--) begin
      repeat (3) @(negedge ref_clk);
      acc(0, 0, 4'hF, 0);
      chk({31'h0, q[27]}, {31'h0, PAT[i]});
      b3(0, 8'h87);
      chk({29'h0, prom_pins}, 32'h7);
      b3(0, 8'h86);
    end
    b3(1, 8'hA0);
    chk({31'h0, rs}, 1);
    acc(1, 0, 4'hF, 0);
    chk({31'h0, q[29]}, 1);
    repeat (10) @(negedge ref_clk);
    acc(1, 0, 4'hF, 0);
    chk({31'h0, q[29]}, 0);
    b3(1, 8'hC0);
    chk({30'h0, bridge_reset, local_bus_reset}, 3);
    chk({16'h0, cmd_codes}, 32'hA5C3);
    b3(1, 8'h80);
    chk({31'h0, bridge_reset}, 1);
    b3(0, 8'h80);
    chk({31'h0, bridge_reset}, 0);
    b3(1, 8'h00);
    pci_req = '{addr: HA, wr: 1'b0, rd: 1'b1, be: 4'hF, wdata: 0};
    #1;
    chk({31'h0, pci_retry}, 1);
    @(negedge ref_clk);
    pci_req = '0;
    @(negedge ref_clk);
    chk({31'h0, pci_ack}, 0);
    b3(1, 8'h80);
    acc(0, 0, 4'hF, 0);
    chk(q, 32'h9800A5C3);
    // A write offered while the clock enable is low must not land
    ce = 1'b0;
    loc_req = '{addr: LA, wr: 1'b1, rd: 1'b0, be: 4'h3, wdata: 32'h1234};
    @(negedge ref_clk);
    loc_req = '0;
    ce = 1'b1;
    @(negedge ref_clk);
    chk({16'h0, cmd_codes}, 32'hA5C3);
    chk({31'h0, loc_ack}, 0);
    results();
  end
endmodule : bus_cmd_prom_init_ctrl_test
